// [cfs_supervisor.sv]
// Purpose: clock failure supervisor: oscillator loss monitor plus independent timeout guard
// Assumes: ext_osc_clk_i and guard_clk_i are pins, sampled by two flip-flops on clk_i
// Notes: loss is seen as a run of sampled cycles with no level change on the oscillator
// Notes on behaviour
// - monitor enabled: watch external oscillator for stopping
// - on loss: oscillator off, system to internal
// - loss reported as non-maskable interrupt
// - guard resets device when refresh misses timeout
// - option strap starts guard after every reset
`timescale 1ns/1ns
module cfs_supervisor
  import cfs_pkg::*;
(
  input wire logic clk_i, // system clock, 25 MHz
  input wire logic rst_i, // async reset, active high
  input wire logic ext_osc_clk_i, // external fast oscillator pin
  input wire logic guard_clk_i, // guard oscillator pin
  input wire logic monitor_en_i, // clock security monitor enable level
  input wire logic osc_on_req_i, // pulse: switch the external oscillator on
  input wire logic select_ext_req_i, // pulse: move system clock to external oscillator
  input wire logic fail_clear_i, // pulse: clear the clock failure flag
  input wire logic hw_guard_opt_i, // option strap: start guard automatically
  input wire logic guard_start_i, // pulse: software start of the guard
  input wire logic guard_refresh_i, // pulse: guard refresh
  input wire logic [GUARD_W-1:0] guard_reload_i, // guard reload value
  input wire logic [GUARD_W-1:0] guard_window_i, // guard refresh window
  output logic ext_osc_on_o, // external oscillator enable
  output logic sys_clk_ext_o, // high: system clock from external oscillator
  output logic nmi_o, // non-maskable interrupt, level until cleared
  output logic guard_running_o, // guard is counting
  output logic [GUARD_W-1:0] guard_count_o, // guard count
  output logic device_reset_o // device reset request, held until rst_i
);
  import cfs_pkg::*;

  logic [2:0] ext_sync_r; // oscillator synchroniser plus one stage for edge compare
  logic [2:0] gclk_sync_r; // guard oscillator synchroniser plus edge stage
  logic [1:0] strap_sync_r; // strap synchroniser
  logic [1:0] strap_wait_r; // cycles since reset release
  logic strap_taken_r; // strap already captured
  logic strap_take; // capture cycle for the strap
  logic ext_edge; // oscillator level changed
  logic armed; // monitoring is live
  logic [LOSS_CNT_W-1:0] silent_r; // cycles without an oscillator edge
  logic loss_now; // loss detected this cycle
  logic osc_on_r; // oscillator enable
  cfs_src_t src_r; // current system clock source
  logic fail_r; // sticky failure flag driving the interrupt
  logic hw_start_r; // one-cycle guard start from the strap
  logic reset_r; // registered reset request

  cfs_guard_if gif ();

  // synchronisers: first stage is read only by the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_sync_r <= 3'h0;
      gclk_sync_r <= 3'h0;
      strap_sync_r <= 2'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_osc_clk_i};
      gclk_sync_r <= {gclk_sync_r[1:0], guard_clk_i};
      strap_sync_r <= {strap_sync_r[0], hw_guard_opt_i};
    end
  end

  // edge from stages two and three; a fast oscillator may alias, but a stopped one never toggles
  assign ext_edge = ext_sync_r[2] ^ ext_sync_r[1];
  // a crystal that is switched off is silent on purpose, so the monitor only counts while it is powered
  assign armed = monitor_en_i && osc_on_r;
  assign loss_now = armed && !ext_edge && (silent_r == LOSS_LIMIT - 1'b1);

  // silence counter: cleared by every edge and while unarmed
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      silent_r <= '0;
    end else if (!armed || ext_edge) begin
      silent_r <= '0;
    end else if (silent_r != LOSS_LIMIT) begin
      silent_r <= silent_r + 1'b1;
    end
  end

  // oscillator enable: loss beats a simultaneous on request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_on_r <= 1'b0;
    end else if (loss_now) begin
      osc_on_r <= 1'b0;
    end else if (osc_on_req_i) begin
      osc_on_r <= 1'b1;
    end
  end

  // clock source: only an explicit reselect with the oscillator on moves it back
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      src_r <= CFS_SRC_INT;
    end else begin
      unique case (src_r)
        CFS_SRC_INT: begin
          if (!loss_now && select_ext_req_i && osc_on_r) begin
            src_r <= CFS_SRC_EXT;
          end
        end
        CFS_SRC_EXT: begin
          if (loss_now) begin
            src_r <= CFS_SRC_INT;
          end
        end
      endcase
    end
  end

  // failure flag: a loss in the clear cycle is kept
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fail_r <= 1'b0;
    end else if (loss_now) begin
      fail_r <= 1'b1;
    end else if (fail_clear_i) begin
      fail_r <= 1'b0;
    end
  end

  // strap capture a few cycles after release, once the synchroniser holds the pin value
  assign strap_take = !strap_taken_r && (strap_wait_r == STRAP_WAIT);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_wait_r <= 2'h0;
      strap_taken_r <= 1'b0;
      hw_start_r <= 1'b0;
    end else begin
      if (strap_wait_r != STRAP_WAIT) begin
        strap_wait_r <= strap_wait_r + 1'b1;
      end
      if (strap_take) begin
        strap_taken_r <= 1'b1;
      end
      hw_start_r <= strap_take && strap_sync_r[1];
    end
  end

  // reset request registered so the output is a clean flop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_r <= 1'b0;
    end else if (gif.fired) begin
      reset_r <= 1'b1;
    end
  end

  // guard wiring; tick from rising edges of the synchronised guard oscillator
  assign gif.tick = gclk_sync_r[1] && !gclk_sync_r[2];
  assign gif.start = guard_start_i;
  assign gif.hw_start = hw_start_r;
  assign gif.refresh = guard_refresh_i; // software must leave slack in the window
  assign gif.reload = guard_reload_i;
  assign gif.window = guard_window_i;

  // the guard keeps its state in its own module, so the loss logic can never disturb its count
  cfs_guard u_guard (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .g(gif.core)
  );

  // status outputs come from flops; the guard flags are decoded from its state register
  assign ext_osc_on_o = osc_on_r;
  assign sys_clk_ext_o = (src_r == CFS_SRC_EXT);
  assign nmi_o = fail_r;
  assign guard_running_o = gif.running;
  assign guard_count_o = gif.count;
  assign device_reset_o = reset_r;

  // checker helper: its own count of quiet armed cycles, so the loss checks do not lean on silent_r
  // a long repetition would be slow to check; a saturating count does the same job cheaply
  logic [LOSS_CNT_W-1:0] quiet_run_r; // consecutive armed cycles with no edge, saturating
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      quiet_run_r <= '0;
    end else if (!armed || ext_edge) begin
      quiet_run_r <= '0; // any edge or a disarm restarts the window
    end else if (quiet_run_r != LOSS_LIMIT) begin
      quiet_run_r <= quiet_run_r + 1'b1;
    end
  end

  // checks below share the system clock and are off while reset is high
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // last quiet cycle of a full window: the trip must follow on the next edge
  sequence s_silent_window;
    armed && !ext_edge && (quiet_run_r == LOSS_LIMIT - 1'b1);
  endsequence

  sequence s_on_internal;
    !sys_clk_ext_o && !ext_osc_on_o;
  endsequence

  a_loss_trips_nmi: assert property (s_silent_window |=> nmi_o && !ext_osc_on_o)
    else $error("stopped oscillator not detected in time");
  a_edge_no_trip: assert property (loss_now |-> quiet_run_r == LOSS_LIMIT - 1'b1)
    else $error("loss flagged too soon after an edge");
  a_loss_switches_int: assert property (loss_now |=> s_on_internal)
    else $error("loss did not move the clock to internal");
  a_nmi_has_cause: assert property ($rose(nmi_o) |-> $past(loss_now))
    else $error("interrupt raised without a loss");
  a_stay_internal: assert property (!sys_clk_ext_o && !select_ext_req_i |=> !sys_clk_ext_o)
    else $error("clock left internal without reselect");
  a_strap_starts_guard: assert property (strap_take && strap_sync_r[1] |=> ##1 guard_running_o)
    else $error("strap did not start the guard");
  a_guard_to_reset: assert property ($rose(gif.fired) |=> device_reset_o)
    else $error("guard fire did not raise reset");
  a_ext_needs_osc: assert property (sys_clk_ext_o |-> ext_osc_on_o)
    else $error("external source selected with the oscillator off");
  a_clear_drops_nmi: assert property (fail_clear_i && !loss_now |=> !nmi_o)
    else $error("interrupt not cleared");
endmodule : cfs_supervisor

// [cfs_pkg.sv]
// Purpose: shared constants and types for the clock failure supervisor
// Assumes: one system clock at 25 MHz (40 ns period)
// Notes: loss window and guard widths are kept here so both modules agree
package cfs_pkg;
  localparam int CLK_PERIOD_NS = 40; // system clock period
  localparam int LOSS_TIME_NS = 400; // least silence on the oscillator that counts as a stop
  localparam int LOSS_CYCLES = (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // rounded up
  localparam int LOSS_CNT_W = 8; // width of the silence counter
  localparam logic [LOSS_CNT_W-1:0] LOSS_LIMIT = LOSS_CNT_W'(LOSS_CYCLES); // silent cycles to trip
  localparam int GUARD_W = 12; // width of the guard down counter
  localparam logic [GUARD_W-1:0] GUARD_COUNT_RST = 12'h0fff; // guard counter after reset
  localparam logic [1:0] STRAP_WAIT = 2'h3; // cycles after release before the strap is taken

  // clock source of the system clock
  typedef enum logic {
    CFS_SRC_INT,
    CFS_SRC_EXT
  } cfs_src_t;

  // independent guard states
  typedef enum logic [1:0] {
    CFS_WD_IDLE,
    CFS_WD_RUN,
    CFS_WD_FIRED
  } cfs_wd_state_t;
endpackage : cfs_pkg

// [cfs_guard_if.sv]
// Purpose: carrier between the supervisor top and its timeout guard
// Assumes: all signals live on clk_i
// Notes: ctl side is the top, core side is the guard counter
`timescale 1ns/1ns
interface cfs_guard_if;
  import cfs_pkg::*;
  logic tick; // one pulse per rising guard oscillator edge
  logic start; // software start pulse
  logic hw_start; // start pulse from the option strap
  logic refresh; // software refresh pulse
  logic [GUARD_W-1:0] reload; // reload value
  logic [GUARD_W-1:0] window; // refresh allowed only at or below this count
  logic [GUARD_W-1:0] count; // current count
  logic running; // guard counting
  logic fired; // guard has requested a device reset

  modport ctl (output tick, start, hw_start, refresh, reload, window, input count, running, fired);
  modport core (input tick, start, hw_start, refresh, reload, window, output count, running, fired);
endinterface : cfs_guard_if

// [cfs_guard.sv]
// Purpose: independent timeout guard counting ticks of its own oscillator
// Assumes: tick is already synchronised into clk_i
// Notes: once fired it holds until rst_i, which the reset it requests will assert
`timescale 1ns/1ns
module cfs_guard
  import cfs_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // async reset, active high
  cfs_guard_if.core g // guard carrier
);
  import cfs_pkg::*;

  cfs_wd_state_t state_r; // guard state
  logic [GUARD_W-1:0] count_r; // down counter
  logic early; // refresh arrived above the window
  logic expire; // counter ran out on a tick

  assign early = g.refresh && (count_r > g.window);
  assign expire = g.tick && (count_r == '0);

  // state: idle until started, then run until a timeout or early refresh
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= CFS_WD_IDLE;
    end else begin
      unique case (state_r)
        CFS_WD_IDLE: begin
          if (g.start || g.hw_start) begin
            state_r <= CFS_WD_RUN;
          end
        end
        CFS_WD_RUN: begin
          if (early || expire) begin
            state_r <= CFS_WD_FIRED;
          end
        end
        CFS_WD_FIRED: begin
          state_r <= CFS_WD_FIRED; // only a reset leaves here
        end
        default: begin
          state_r <= CFS_WD_FIRED; // illegal code: fail safe
        end
      endcase
    end
  end

  // counter: loads on start and in-window refresh, steps down on each guard tick while running
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_r <= GUARD_COUNT_RST;
    end else if (state_r == CFS_WD_IDLE && (g.start || g.hw_start)) begin
      count_r <= g.reload;
    end else if (state_r == CFS_WD_RUN && g.refresh && !early) begin
      count_r <= g.reload; // a slow main clock refreshes too late to get here
    end else if (state_r == CFS_WD_RUN && g.tick && count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  assign g.count = count_r;
  assign g.running = (state_r == CFS_WD_RUN);
  assign g.fired = (state_r == CFS_WD_FIRED);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_guard_timeout_fires: assert property (g.running && g.tick && count_r == '0 |=> g.fired && !g.running)
    else $error("guard did not fire on timeout");
  a_guard_early_refresh: assert property (g.running && g.refresh && count_r > g.window |=> g.fired)
    else $error("early refresh did not fire the guard");
  a_guard_fired_holds: assert property (g.fired |=> g.fired [*8])
    else $error("guard left the fired state");
endmodule : cfs_guard

// [cfs_osc_model.sv]
// Purpose: behavioural external fast oscillator for the supervisor bench
// Assumes: run_i high means the crystal is powered and swinging
// Notes: a dead crystal freezes at its last level, the case the monitor must catch
`timescale 1ns/1ns
module cfs_osc_model #(
  parameter int HALF_NS = 57 // half period, unrelated in phase to the 40 ns clock
) (
  input wire logic run_i, // enabled by the block and healthy
  output logic osc_o // oscillator pin
);
  // swing while running, hold still otherwise
  initial begin
    osc_o = 1'b0;
    forever begin
      #HALF_NS;
      if (run_i === 1'b1) begin
        osc_o = ~osc_o;
      end
    end
  end
endmodule : cfs_osc_model

// [test_cfs_supervisor.sv]
// Purpose: self-checking bench for the clock failure supervisor
// Assumes: inputs change by nba at the rising edge; outputs read at a later edge
// Notes: guard ticks are made by hand, four cycles each, so counts stay predictable
`timescale 1ns/1ns
module test_cfs_supervisor;
  import cfs_pkg::*;
  logic clk_i = 1'b0; // system clock
  logic rst_i = 1'b1; // async reset
  logic osc_ok = 1'b1; // crystal healthy
  logic ext_osc_clk_i; // pin from the model
  logic guard_clk_i = 1'b0; // guard oscillator pin
  logic monitor_en_i = 1'b0; // monitor enable
  logic osc_on_req_i = 1'b0; // oscillator on pulse
  logic select_ext_req_i = 1'b0; // source select pulse
  logic fail_clear_i = 1'b0; // nmi clear pulse
  logic hw_guard_opt_i = 1'b0; // guard strap
  logic guard_start_i = 1'b0; // guard start pulse
  logic guard_refresh_i = 1'b0; // guard refresh pulse
  logic [GUARD_W-1:0] guard_reload_i = 12'h0004; // reload
  logic [GUARD_W-1:0] guard_window_i = 12'h0fff; // window
  logic ext_osc_on_o, sys_clk_ext_o, nmi_o, guard_running_o, device_reset_o; // outputs
  logic [GUARD_W-1:0] guard_count_o; // guard count
  int n_fail = 0; // mismatches
  int checks = 0; // comparisons

  cfs_supervisor uut (.clk_i, .rst_i, .ext_osc_clk_i, .guard_clk_i, .monitor_en_i, .osc_on_req_i,
    .select_ext_req_i, .fail_clear_i, .hw_guard_opt_i, .guard_start_i, .guard_refresh_i, .guard_reload_i,
    .guard_window_i, .ext_osc_on_o, .sys_clk_ext_o, .nmi_o, .guard_running_o, .guard_count_o, .device_reset_o);
  // crystal swings only while the block powers it
  cfs_osc_model osc (.run_i(ext_osc_on_o & osc_ok), .osc_o(ext_osc_clk_i));

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk_bit

  task chk_cnt(input logic [GUARD_W-1:0] got, input logic [GUARD_W-1:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h", $time, what, got);
    end
  endtask : chk_cnt

  // reset held five cycles; strap set while reset is high
  task do_reset(input logic opt);
    rst_i <= 1'b1;
    hw_guard_opt_i <= opt;
    monitor_en_i <= 1'b0;
    cyc(5);
    rst_i <= 1'b0;
    cyc(1);
  endtask : do_reset

  // one guard tick: two cycles high, two low, so the synchroniser sees it
  task tick;
    guard_clk_i <= 1'b1;
    cyc(2);
    guard_clk_i <= 1'b0;
    cyc(2);
  endtask : tick

  // power the crystal, then select it on the very next cycle
  task go_ext;
    osc_on_req_i <= 1'b1;
    cyc(1);
    osc_on_req_i <= 1'b0;
    select_ext_req_i <= 1'b1;
    cyc(1);
    select_ext_req_i <= 1'b0;
    cyc(10);
  endtask : go_ext

  task t_reset;
    do_reset(1'b0);
    chk_cnt(guard_count_o, 12'h0fff, "count reset");
    chk_bit(sys_clk_ext_o, 1'b0, "source reset");
    chk_bit(ext_osc_on_o, 1'b0, "osc reset");
  endtask : t_reset

  task t_loss;
    int k;
    do_reset(1'b0);
    go_ext;
    monitor_en_i <= 1'b1; // armed only after the crystal settled
    cyc(30);
    chk_bit(sys_clk_ext_o, 1'b1, "not external");
    chk_bit(nmi_o, 1'b0, "false alarm");
    osc_ok <= 1'b0;
    cyc(10);
    chk_bit(nmi_o, 1'b0, "alarm too early");
    k = 0;
    while (nmi_o !== 1'b1 && k < 12) begin
      cyc(1);
      k++;
    end
    chk_bit(nmi_o, 1'b1, "no nmi");
    cyc(1);
    chk_bit(ext_osc_on_o, 1'b0, "osc left on");
    chk_bit(sys_clk_ext_o, 1'b0, "not internal");
    osc_ok <= 1'b1;
    select_ext_req_i <= 1'b1; // must be refused while the crystal is off
    cyc(1);
    select_ext_req_i <= 1'b0;
    cyc(20);
    chk_bit(sys_clk_ext_o, 1'b0, "left internal");
    chk_bit(nmi_o, 1'b1, "nmi not sticky");
    fail_clear_i <= 1'b1;
    cyc(1);
    fail_clear_i <= 1'b0;
    cyc(1);
    chk_bit(nmi_o, 1'b0, "nmi kept");
    monitor_en_i <= 1'b0; // off while the crystal is powered again
    go_ext;
    chk_bit(sys_clk_ext_o, 1'b1, "reselect refused");
    osc_ok <= 1'b0;
    cyc(25);
    chk_bit(nmi_o, 1'b0, "alarm while disabled");
    osc_ok <= 1'b1;
  endtask : t_loss

  task t_guard;
    do_reset(1'b0);
    guard_reload_i <= 12'h0004;
    guard_window_i <= 12'h0fff;
    guard_start_i <= 1'b1;
    cyc(1);
    guard_start_i <= 1'b0;
    cyc(1);
    chk_cnt(guard_count_o, 12'h0004, "no reload");
    repeat (6) begin
      tick;
      guard_refresh_i <= 1'b1; // serviced well before zero
      cyc(1);
      guard_refresh_i <= 1'b0;
    end
    cyc(2);
    repeat (4) tick;
    cyc(2);
    chk_cnt(guard_count_o, 12'h0000, "not at zero");
    chk_bit(device_reset_o, 1'b0, "reset too early");
    tick;
    cyc(3);
    chk_bit(device_reset_o, 1'b1, "no timeout reset");
    chk_bit(guard_running_o, 1'b0, "still running");
  endtask : t_guard

  // refresh while the count is above the window must reset
  task t_window;
    do_reset(1'b0);
    guard_reload_i <= 12'h0008;
    guard_window_i <= 12'h0002;
    guard_start_i <= 1'b1;
    cyc(1);
    guard_start_i <= 1'b0;
    cyc(2);
    guard_refresh_i <= 1'b1;
    cyc(1);
    guard_refresh_i <= 1'b0;
    cyc(3);
    chk_bit(device_reset_o, 1'b1, "early refresh kept");
  endtask : t_window

  task t_strap;
    do_reset(1'b1);
    cyc(10);
    chk_bit(guard_running_o, 1'b1, "strap ignored");
    do_reset(1'b0);
    cyc(10);
    chk_bit(guard_running_o, 1'b0, "guard self-started");
  endtask : t_strap

  task close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // main sequence
  initial begin
    t_reset;
    t_loss;
    t_guard;
    t_window;
    t_strap;
    close_out;
  end

  // hang guard: the tests need about 240 cycles
  initial begin
    #40000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    close_out;
  end
endmodule : test_cfs_supervisor
